/* File: src/scrc_run_control.v */
// run control and error flag clearing for two serial units of four channels
// Notes on behaviour
// - writing 1 to a clear trigger clears its error flag; 0 does nothing
// - clear triggers fall back to 0 on their own once the flag clears
// - reading an error clear register always gives zero
// - framing trigger bit 2, parity bit 1, overrun bit 0; upper bits zero
// - error clear register takes word writes and low byte writes
// - start sets the enable bit, stop clears it
// - a stopped channel keeps settings, shifter, pins and error flags
// - stopping clears transfer active and buffer full status bits
// - clock level write ignored while enabled; shown on pin while stopped
// - enable status is read only, word or low byte readable
// - start enters wait state, aborting any running transfer
// - start triggers self clear once enabled; start register reads zero
// - stop clears enable and halts the channel's operation
// - stop triggers self clear once disabled; stop register reads zero
// - start and stop take word, byte and single bit writes
// - two units with channels 0 to 3, one bit each per register
// - reset clears all these registers, every channel stopped
// - error flags stay set until their clear trigger is written
// - unit 1 channel 2 has no error flags nor clear register
`timescale 1ns/1ps
`include "scrc_map.vh"
module scrc_run_control (
  input wire clk_sys,
  input wire reset_n,
  input wire [19:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_word,
  input wire [15:0] bus_wdata,
  input wire [15:0] so_cko_wdata,
  input wire so_cko_wr,
  input wire [7:0] err_event_fe,
  input wire [7:0] err_event_pe,
  input wire [7:0] err_event_ov,
  input wire [7:0] engine_cko,
  output reg [15:0] bus_rdata_q,
  output reg [7:0] channel_enabled_q,
  output reg [7:0] framing_error_flag_q,
  output reg [7:0] parity_error_flag_q,
  output reg [7:0] overrun_error_flag_q,
  output reg [7:0] cko_pin_q,
  output reg [7:0] restart_pulse_q,
  output reg [7:0] status_clear_pulse_q
);

  // ****************************************************************
  // write decode
  // ****************************************************************
  // byte writes to the low byte leave bits 15..8 unwritten; those are
  // zero anyway, so only the low byte matters for every trigger
  wire [7:0] wlow;
  reg [7:0] start_trigger;
  reg [7:0] stop_trigger;
  reg [23:0] clear_trigger;
  assign wlow = bus_wdata[7:0];

  always @* begin
    start_trigger = 8'h00;
    stop_trigger = 8'h00;
    clear_trigger = 24'h000000;
    if (bus_wr) begin
      case (bus_addr)
        `SCRC_ADDR_START_U0: start_trigger[3:0] = wlow[3:0];
        `SCRC_ADDR_START_U1: start_trigger[7:4] = wlow[3:0];
        `SCRC_ADDR_STOP_U0: stop_trigger[3:0] = wlow[3:0];
        `SCRC_ADDR_STOP_U1: stop_trigger[7:4] = wlow[3:0];
        `SCRC_ADDR_ERRCLR_U0_CH0: clear_trigger[2:0] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U0_CH1: clear_trigger[5:3] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U0_CH2: clear_trigger[8:6] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U0_CH3: clear_trigger[11:9] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U1_CH0: clear_trigger[14:12] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U1_CH1: clear_trigger[17:15] = wlow[2:0];
        `SCRC_ADDR_ERRCLR_U1_CH3: clear_trigger[23:21] = wlow[2:0];
        default: start_trigger = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  // triggers are single-cycle strobes, so they never stay set
  wire [7:0] en_w;
  wire [7:0] cko_w;
  wire [7:0] restart_w;
  wire [7:0] halt_w;
  wire [23:0] flags_w;
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : g_ch
      scrc_channel #(
        .HAS_ERR((c == 6) ? 0 : 1)
      ) u_ch (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start_trigger(start_trigger[c]),
        .stop_trigger(stop_trigger[c]),
        .clear_trigger(clear_trigger[3*c+2:3*c]),
        .err_event({err_event_fe[c], err_event_pe[c], err_event_ov[c]}),
        .cko_write(so_cko_wr),
        .cko_wdata(so_cko_wdata[8+(c%4)]),
        .engine_cko(engine_cko[c]),
        .enabled_q(en_w[c]),
        .err_flags_q(flags_w[3*c+2:3*c]),
        .cko_level_q(cko_w[c]),
        .restart_q(restart_w[c]),
        .halt_q(halt_w[c])
      );
    end
  endgenerate

  // ****************************************************************
  // output registers
  // ****************************************************************
  integer k;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      channel_enabled_q <= 8'h00;
      framing_error_flag_q <= 8'h00;
      parity_error_flag_q <= 8'h00;
      overrun_error_flag_q <= 8'h00;
      cko_pin_q <= `SCRC_RESET_CKO;
      restart_pulse_q <= 8'h00;
      status_clear_pulse_q <= 8'h00;
    end else begin
      channel_enabled_q <= en_w;
      for (k = 0; k < 8; k = k + 1) begin
        framing_error_flag_q[k] <= flags_w[3*k+`SCRC_BIT_FRAMING_CLR];
        parity_error_flag_q[k] <= flags_w[3*k+`SCRC_BIT_PARITY_CLR];
        overrun_error_flag_q[k] <= flags_w[3*k+`SCRC_BIT_OVERRUN_CLR];
      end
      cko_pin_q <= cko_w;
      restart_pulse_q <= restart_w;
      status_clear_pulse_q <= halt_w | restart_w;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // only enable status reads nonzero; triggers read zero
  reg [15:0] rdata_d;
  always @* begin
    rdata_d = `SCRC_RESET_WORD;
    case (bus_addr)
      `SCRC_ADDR_ENSTAT_U0: rdata_d = {12'h000, en_w[3:0]};
      `SCRC_ADDR_ENSTAT_U1: rdata_d = {12'h000, en_w[7:4]};
      default: rdata_d = `SCRC_RESET_WORD;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_q <= `SCRC_RESET_WORD;
    end else if (bus_rd) begin
      bus_rdata_q <= rdata_d;
    end
  end

endmodule // scrc_run_control

/* File: src/scrc_map.vh */
// register map, field positions and reset values of the serial channel run control
`ifndef SCRC_MAP_VH
`define SCRC_MAP_VH
// ****************************************************************
// byte addresses (word registers, even address)
// ****************************************************************
`define SCRC_ADDR_ERRCLR_U0_CH0 20'hF0108
`define SCRC_ADDR_ERRCLR_U0_CH1 20'hF010A
`define SCRC_ADDR_ERRCLR_U0_CH2 20'hF010C
`define SCRC_ADDR_ERRCLR_U0_CH3 20'hF010E
`define SCRC_ADDR_ENSTAT_U0 20'hF0120
`define SCRC_ADDR_START_U0 20'hF0122
`define SCRC_ADDR_STOP_U0 20'hF0124
`define SCRC_ADDR_ERRCLR_U1_CH0 20'hF0148
`define SCRC_ADDR_ERRCLR_U1_CH1 20'hF014A
`define SCRC_ADDR_ERRCLR_U1_CH3 20'hF014E
`define SCRC_ADDR_ENSTAT_U1 20'hF0160
`define SCRC_ADDR_START_U1 20'hF0162
`define SCRC_ADDR_STOP_U1 20'hF0164
// ****************************************************************
// field positions
// ****************************************************************
`define SCRC_BIT_FRAMING_CLR 2
`define SCRC_BIT_PARITY_CLR 1
`define SCRC_BIT_OVERRUN_CLR 0
`define SCRC_BIT_TRANSFER_ACTIVE 6
`define SCRC_BIT_BUFFER_FULL 5
// ****************************************************************
// reset values
// ****************************************************************
`define SCRC_RESET_WORD 16'h0000
`define SCRC_RESET_CKO 8'hFF
`endif

/* File: src/scrc_channel.v */
// one serial channel: run state, sticky error flags, clock output level
`timescale 1ns/1ps
`include "scrc_map.vh"
module scrc_channel #(
  parameter HAS_ERR = 1
) (
  input wire clk_sys,
  input wire reset_n,
  input wire start_trigger,
  input wire stop_trigger,
  input wire [2:0] clear_trigger,
  input wire [2:0] err_event,
  input wire cko_write,
  input wire cko_wdata,
  input wire engine_cko,
  output reg enabled_q,
  output reg [2:0] err_flags_q,
  output reg cko_level_q,
  output reg restart_q,
  output reg halt_q
);

  // ****************************************************************
  // run state
  // ****************************************************************
  // stop wins over a simultaneous start
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enabled_q <= 1'b0;
      restart_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      restart_q <= start_trigger & ~stop_trigger;
      halt_q <= stop_trigger;
      if (stop_trigger) begin
        enabled_q <= 1'b0;
      end else if (start_trigger) begin
        enabled_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // sticky error flags
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_err
      // an error in the clearing cycle keeps the flag set
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          err_flags_q[i] <= 1'b0;
        end else if (HAS_ERR == 0) begin
          err_flags_q[i] <= 1'b0;
        end else if (err_event[i]) begin
          err_flags_q[i] <= 1'b1;
        end else if (clear_trigger[i]) begin
          err_flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // clock output level
  // ****************************************************************
  // software level only counts while stopped; follows engine_cko while running
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cko_level_q <= 1'b1;
    end else if (enabled_q) begin
      cko_level_q <= engine_cko;
    end else if (cko_write) begin
      cko_level_q <= cko_wdata;
    end
  end

endmodule // scrc_channel

/* File: tb/scrc_run_control_assertions.sv */
// concurrent checks on the ports of the serial channel run control
`timescale 1ns/1ps
`include "scrc_map.vh"
module scrc_run_control_assertions (
  input wire clk_sys,
  input wire reset_n,
  input wire [19:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_wdata,
  input wire [7:0] err_event_fe,
  input wire [7:0] err_event_pe,
  input wire [15:0] bus_rdata_q,
  input wire [7:0] channel_enabled_q,
  input wire [7:0] framing_error_flag_q,
  input wire [7:0] parity_error_flag_q,
  input wire [7:0] overrun_error_flag_q,
  input wire [7:0] restart_pulse_q,
  input wire [7:0] status_clear_pulse_q
);
  // ****************************************
  // decoded writes and properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire st_w = bus_wr && bus_addr == `SCRC_ADDR_START_U0;
  wire sp_w = bus_wr && bus_addr == `SCRC_ADDR_STOP_U0;
  wire c0_w = bus_wr && bus_addr == `SCRC_ADDR_ERRCLR_U0_CH0;
  a_start_sets_enable: assert property (st_w |-> ##2
    (channel_enabled_q[3:0] & $past(bus_wdata[3:0], 2)) == $past(bus_wdata[3:0], 2))
    else $error("start did not enable");
  a_stop_clears_enable: assert property (sp_w |-> ##2
    (channel_enabled_q[3:0] & $past(bus_wdata[3:0], 2)) == 4'h0) else $error("stop failed");
  a_trigger_reads_zero: assert property (bus_rd && (bus_addr == `SCRC_ADDR_START_U0 ||
    bus_addr == `SCRC_ADDR_STOP_U0 || bus_addr == `SCRC_ADDR_ERRCLR_U0_CH0)
    |=> bus_rdata_q == 16'h0000) else $error("trigger read not zero");
  a_status_read_back: assert property (bus_rd && bus_addr == `SCRC_ADDR_ENSTAT_U0
    |=> bus_rdata_q == {12'h000, channel_enabled_q[3:0]}) else $error("status read wrong");
  a_clear_framing_flag: assert property (c0_w && bus_wdata[2] && !err_event_fe[0]
    |-> ##2 !framing_error_flag_q[0]) else $error("framing flag not cleared");
  a_flag_stays_set: assert property ($fell(framing_error_flag_q[0])
    |-> $past(c0_w, 2) && $past(bus_wdata[2], 2)) else $error("flag fell without clear");
  a_event_sets_flag: assert property (err_event_pe[0] |-> ##2 parity_error_flag_q[0])
    else $error("parity flag not set");
  a_no_absent_flags: assert property (!(framing_error_flag_q[6] ||
    parity_error_flag_q[6] || overrun_error_flag_q[6])) else $error("absent flag set");
  a_start_restarts: assert property (st_w && bus_wdata[0] |-> ##2 restart_pulse_q[0])
    else $error("no restart pulse");
  a_stop_clears_status: assert property (sp_w && bus_wdata[0] |-> ##2
    status_clear_pulse_q[0]) else $error("no status clear pulse on stop");
  c_start: cover property (st_w && bus_wdata[0]);
  c_stop: cover property (sp_w && bus_wdata[0]);
  c_clear: cover property (c0_w && bus_wdata[2]);
endmodule // scrc_run_control_assertions
bind scrc_run_control scrc_run_control_assertions chk_u (.*);

/* File: tb/scrc_run_control_bench.sv */
// self-checking bench of the serial channel run control
`timescale 1ns/1ps
`include "scrc_map.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module scrc_run_control_bench;
  logic clk_sys = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, bus_word = 0, so_cko_wr = 0;
  logic rd_seen = 0;
  logic [19:0] bus_addr = '0, ub;
  logic [15:0] bus_wdata = '0, so_cko_wdata = '0, bus_rdata_q, note;
  logic [7:0] evm = '0, engine_cko = '0, channel_enabled_q, cko_pin_q;
  logic [7:0] framing_error_flag_q, parity_error_flag_q, overrun_error_flag_q;
  logic [7:0] restart_pulse_q, status_clear_pulse_q;
  logic [3:0] m, s;
  logic [19:0] eca [8];
  logic [15:0] notes [$];
  integer fails = 0, n_compared = 0, cyc = 0, seed = 32'hE805, i, b, u;
  // ****************************************
  // clock, design, monitor, tasks
  // ****************************************
  initial forever #2.5 clk_sys = ~clk_sys;
  scrc_run_control dut_u (.err_event_fe(evm), .err_event_pe(evm), .err_event_ov(evm), .*);
  // read results are matched against the oldest note
  always @(posedge clk_sys) rd_seen <= bus_rd;
  always @(negedge clk_sys) if (rd_seen) begin
    note = notes.pop_front();
    `CHK(bus_rdata_q, note)
  end
  // hang guard
  always @(posedge clk_sys) if (++cyc == 20000) begin
    fails++;
    final_report();
  end
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    bus_word = $random(seed);
    bus_wr = 1;
    @(negedge clk_sys);
    bus_wr = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1;
    notes.push_back(e);
    @(negedge clk_sys);
    bus_rd = 0;
  endtask
  task automatic pulse(input logic [7:0] v, input bit cko);
    @(negedge clk_sys);
    if (cko) so_cko_wdata = {v, 8'h00};
    else evm = v;
    so_cko_wr = cko;
    @(negedge clk_sys);
    evm = '0;
    so_cko_wr = 0;
    repeat (2) @(negedge clk_sys);
  endtask
  task final_report;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    eca = '{`SCRC_ADDR_ERRCLR_U0_CH0, `SCRC_ADDR_ERRCLR_U0_CH1, `SCRC_ADDR_ERRCLR_U0_CH2,
      `SCRC_ADDR_ERRCLR_U0_CH3, `SCRC_ADDR_ERRCLR_U1_CH0, `SCRC_ADDR_ERRCLR_U1_CH1,
      20'h00000, `SCRC_ADDR_ERRCLR_U1_CH3};
    repeat (2) @(negedge clk_sys);
    reset_n = 1;
    `CHK({channel_enabled_q, cko_pin_q, framing_error_flag_q}, 24'h00FF00)
    rd(`SCRC_ADDR_ENSTAT_U1, '0);
    for (u = 0; u < 2; u++) begin
      ub = u ? 20'h00040 : 20'h00000;
      m = $random(seed);
      s = $random(seed);
      wr(`SCRC_ADDR_START_U0 + ub, {12'h000, m});
      rd(`SCRC_ADDR_ENSTAT_U0 + ub, {12'h000, m});
      rd(`SCRC_ADDR_START_U0 + ub, '0);
      wr(`SCRC_ADDR_STOP_U0 + ub, {12'h000, s});
      rd(`SCRC_ADDR_ENSTAT_U0 + ub, {12'h000, m & ~s});
      rd(`SCRC_ADDR_STOP_U0 + ub, '0);
      wr(`SCRC_ADDR_ENSTAT_U0 + ub, 16'h000F);
      wr(20'hF0126 + ub, 16'h000F);
      rd(`SCRC_ADDR_ENSTAT_U0 + ub, {12'h000, m & ~s});
      wr(`SCRC_ADDR_STOP_U0 + ub, 16'h000F);
    end
    for (i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 0);
      `CHK(overrun_error_flag_q[i], i != 6)
      if (i != 6) begin
        wr(eca[i], 16'h0000);
        @(negedge clk_sys);
        `CHK(parity_error_flag_q[i], 1'h1)
        for (b = 2; b >= 0; b--) begin
          wr(eca[i], 16'h0001 << b);
          @(negedge clk_sys);
          `CHK({framing_error_flag_q[i], parity_error_flag_q[i], overrun_error_flag_q[i]},
            3'h7 >> (3 - b))
        end
        rd(eca[i], '0);
      end
    end
    engine_cko = 8'hFF;
    pulse(8'h00, 1);
    `CHK(cko_pin_q[0], 1'h0)
    wr(`SCRC_ADDR_START_U0, 16'h0001);
    @(negedge clk_sys);
    `CHK({restart_pulse_q[0], status_clear_pulse_q[0]}, 2'h3)
    engine_cko = 8'h00;
    pulse(8'hFF, 1);
    `CHK(cko_pin_q[0], 1'h0)
    engine_cko = 8'h01;
    repeat (3) @(negedge clk_sys);
    `CHK(cko_pin_q[0], 1'h1)
    final_report();
  end
endmodule // scrc_run_control_bench
